// >>> src/chpc_pkg.sv
// Purpose: Shared constants and types for the card host-pin control block
// Assumes: 40 MHz core clock, one clock domain
// Notes: Pin-level polarities are named here so the logic holds no bare numbers
// Behaviour
// RULE1 - PC Card modes: reset pin active high; high or open at power-up resets.
// RULE2 - True IDE mode: host hardware reset pin is active low.
// RULE3 - PC Card modes: card never asserts wait, so cycles never stretch.
// RULE4 - True IDE outside Ultra DMA: wait pin serves as ready indication.
// RULE5 - Ultra DMA write: ready line shows receive readiness; card may drop it.
// RULE6 - Ultra DMA read: card makes data strobe, one word per edge.
// RULE7 - Card pauses data-out burst by stopping strobe edges.
// RULE8 - Memory mode: host write strobe writes memory-cycle data to registers.
// RULE9 - I/O mode: write strobe only writes configuration registers.
// RULE10 - True IDE mode: write strobe input ignored; host holds it high.
// RULE11 - Memory mode: write-protect output driven low after reset initialization.
// RULE12 - I/O mode: 16-bit pin low when addressed port is 16-bit capable.
// RULE13 - True IDE: 16-bit pin low when word-wide transfer expected.
// RULE14 - Host mode-select pin stable through reset; high PC Card, low IDE.
// RULE15 - During any reset, ignore strobes and hold status outputs at reset levels.
package chpc_pkg;

  // ****************************************************************
  // Timing and sizes
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int INIT_TIME_NS = 2000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_CYCLES = 3;
  localparam int CNT_W = 8;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;

  // ****************************************************************
  // Pin levels
  // ****************************************************************
  localparam logic LVL_HI = 1'b1;
  localparam logic LVL_LO = 1'b0;
  localparam logic [2:0] SYNC_RST = 3'h7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    CHPC_ST_STRAP = 2'b00,
    CHPC_ST_RESET = 2'b01,
    CHPC_ST_INIT = 2'b10,
    CHPC_ST_RUN = 2'b11
  } chpc_state_t;

  // Status from the card core, same clock domain
  typedef struct packed {
    logic io_mode;
    logic ready;
    logic port16;
    logic word_xfer;
    logic udma_rd;
    logic udma_wr;
    logic wr_ready;
    logic cfg_addr;
  } chpc_core_t;

  // Registered pin drive toward the host
  typedef struct packed {
    logic wait_n;
    logic wp_io16;
    logic dstrobe;
    logic data_oe;
    logic [DATA_W-1:0] data;
  } chpc_pins_t;

endpackage

// >>> src/chpc_top.sv
// Purpose: Device-side control pins of a removable flash card host port
// Assumes: Host pins are asynchronous and pass two flip-flops before use
// Notes: Ultra DMA read data drains from an 8-word FIFO fed by the core
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Data FIFO
// ****************************************************************
module chpc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;
  logic in_ready_reg, in_ready_next;

  // Pointer and fill arithmetic
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_next = push ? ((wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1) : wp_reg;
    rp_next = pop ? ((rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1) : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    // Full flag looks ahead one cycle so ready can come from a flop
    in_ready_next = (cnt_next != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      in_ready_reg <= 1'b1;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      in_ready_reg <= in_ready_next;
    end
  end

  // Storage has no reset; only valid words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  assign in_ready = in_ready_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rp_reg];
endmodule

// ****************************************************************
// Pin control top
// ****************************************************************
module chpc_top
  import chpc_pkg::*;
#(
  parameter int INIT_CNT = INIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin_card_reset,
  input wire logic pin_mode_sel_n,
  input wire logic pin_we_n,
  input wire chpc_core_t core,
  input wire logic [DATA_W-1:0] src_data,
  input wire logic src_valid,
  output logic src_ready,
  output chpc_pins_t pins,
  output logic ide_mode,
  output logic card_busy,
  output logic mem_we_pulse,
  output logic cfg_we_pulse
);
  // Synchroniser stages: [0] reset pin, [1] mode pin, [2] write strobe
  logic [2:0] s1_reg, s2_reg, s3_reg;
  chpc_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic ide_reg, ide_next;
  chpc_pins_t pins_reg, pins_next;
  logic busy_reg, busy_next;
  logic mem_we_reg, mem_we_next, cfg_we_reg, cfg_we_next;
  logic half_reg, half_next;
  logic rst_active, we_fall, running, udma_any;
  logic [DATA_W-1:0] fifo_data;
  logic fifo_valid, fifo_pop;

  chpc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) i_chpc_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_data(src_data),
    .in_valid(src_valid),
    .in_ready(src_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // Two-flop synchronisers plus an edge stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= SYNC_RST;
      s2_reg <= SYNC_RST;
      s3_reg <= SYNC_RST;
    end else begin
      s1_reg <= {pin_we_n, pin_mode_sel_n, pin_card_reset};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Reset polarity follows the latched mode
  always_comb begin
    rst_active = ide_reg ? (s2_reg[0] == LVL_LO) : (s2_reg[0] == LVL_HI); // [RULE1] [RULE2]
    we_fall = (s3_reg[2] == LVL_HI) && (s2_reg[2] == LVL_LO);
    running = (state_reg == CHPC_ST_RUN);
    udma_any = core.udma_rd || core.udma_wr;
  end

  // Sequencer and pin drive, next values
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ide_next = ide_reg;
    unique case (state_reg)
      CHPC_ST_STRAP: begin
        // Mode is caught once the synchronised pin has settled
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(STRAP_CYCLES - 1)) begin
          ide_next = (s2_reg[1] == LVL_LO); // [RULE14]
          state_next = CHPC_ST_RESET;
          cnt_next = '0;
        end
      end
      CHPC_ST_RESET: begin
        // Open or high pin at power-up keeps the card here in PC modes
        if (!rst_active) begin
          state_next = CHPC_ST_INIT; // [RULE1]
        end
        cnt_next = '0;
      end
      CHPC_ST_INIT: begin
        cnt_next = cnt_reg + 1'b1;
        if (rst_active) begin
          state_next = CHPC_ST_RESET;
          cnt_next = '0;
        end else if (cnt_reg == CNT_W'(INIT_CNT - 1)) begin
          state_next = CHPC_ST_RUN;
        end
      end
      CHPC_ST_RUN: begin
        if (rst_active) begin
          state_next = CHPC_ST_RESET;
        end
      end
    endcase

    busy_next = !(state_next == CHPC_ST_RUN);
    // Strobes are dropped outright while not running
    mem_we_next = running && !ide_reg && !core.io_mode && we_fall; // [RULE8] [RULE15]
    cfg_we_next = running && !ide_reg && core.io_mode && we_fall && core.cfg_addr; // [RULE9]

    // Wait/ready pin: never asserted in PC modes
    pins_next = pins_reg;
    pins_next.wait_n = LVL_HI; // [RULE3]
    if (running && ide_reg) begin
      if (core.udma_wr) begin
        pins_next.wait_n = core.wr_ready; // [RULE5]
      end else if (!core.udma_rd) begin
        pins_next.wait_n = core.ready; // [RULE4]
      end
    end

    // Shared write-protect / 16-bit pin, held high until initialised
    pins_next.wp_io16 = LVL_HI; // [RULE15]
    if (running) begin
      if (ide_reg) begin
        pins_next.wp_io16 = !core.word_xfer; // [RULE13]
      end else if (core.io_mode) begin
        pins_next.wp_io16 = !core.port16; // [RULE12]
      end else begin
        pins_next.wp_io16 = LVL_LO; // [RULE11]
      end
    end

    // Read burst: load a word, then toggle the strobe; empty FIFO stalls edges
    fifo_pop = running && ide_reg && core.udma_rd && !half_reg && fifo_valid;
    half_next = half_reg;
    pins_next.data_oe = running && ide_reg && core.udma_rd;
    if (fifo_pop) begin
      pins_next.data = fifo_data;
      half_next = 1'b1;
    end else if (half_reg) begin
      pins_next.dstrobe = !pins_reg.dstrobe; // [RULE6] [RULE7]
      half_next = 1'b0;
    end
    if (!(running && ide_reg && udma_any)) begin
      half_next = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CHPC_ST_STRAP;
      cnt_reg <= '0;
      ide_reg <= 1'b0;
      busy_reg <= 1'b1;
      mem_we_reg <= 1'b0;
      cfg_we_reg <= 1'b0;
      half_reg <= 1'b0;
      pins_reg <= '{wait_n: LVL_HI, wp_io16: LVL_HI, dstrobe: LVL_HI, data_oe: 1'b0, data: '0};
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ide_reg <= ide_next;
      busy_reg <= busy_next;
      mem_we_reg <= mem_we_next;
      cfg_we_reg <= cfg_we_next;
      half_reg <= half_next;
      pins_reg <= pins_next;
    end
  end

  assign pins = pins_reg;
  assign ide_mode = ide_reg;
  assign card_busy = busy_reg;
  assign mem_we_pulse = mem_we_reg;
  assign cfg_we_pulse = cfg_we_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence word_loaded;
    fifo_pop;
  endsequence
  sequence strobe_edge;
    pins_reg.dstrobe != $past(pins_reg.dstrobe);
  endsequence

  AST_PC_RESET_POL: assert property (running && !ide_reg && s2_reg[0] |=> state_reg == CHPC_ST_RESET) // [RULE1]
    else $error("PC mode reset high did not reset card");
  AST_IDE_RESET_POL: assert property (running && ide_reg && !s2_reg[0] |=> state_reg == CHPC_ST_RESET) // [RULE2]
    else $error("IDE mode reset low did not reset card");
  AST_PC_NO_WAIT: assert property (!ide_reg && state_reg != CHPC_ST_STRAP |=> pins_reg.wait_n) // [RULE3]
    else $error("Wait asserted in PC mode");
  AST_IDE_IORDY: assert property (running && ide_reg && !udma_any |=> pins_reg.wait_n == $past(core.ready)) // [RULE4]
    else $error("Ready pin does not follow core ready");
  AST_DDMARDY: assert property (running && ide_reg && core.udma_wr |=> pins_reg.wait_n == $past(core.wr_ready)) // [RULE5]
    else $error("Receive-ready pin wrong during write");
  // Word shows one cycle after the pop, its strobe edge one cycle later
  AST_WORD_STROBE: assert property (word_loaded |=> ##1 strobe_edge) // [RULE6]
    else $error("Loaded word not followed by strobe edge");
  AST_PAUSE: assert property (!fifo_valid && !half_reg |=> $stable(pins_reg.dstrobe)) // [RULE7]
    else $error("Strobe moved with no data");
  AST_IDE_NO_WE: assert property (ide_reg |-> !mem_we_reg && !cfg_we_reg) // [RULE10]
    else $error("Write strobe acted in IDE mode");
  AST_IO_CFG_ONLY: assert property (cfg_we_reg |-> $past(core.io_mode && core.cfg_addr)) // [RULE9]
    else $error("I/O write strobe outside configuration space");
  AST_WP_LOW: assert property (running && !ide_reg && !core.io_mode |=> !pins_reg.wp_io16) // [RULE11]
    else $error("Write protect not low after init");
  AST_IOIS16: assert property (running && !ide_reg && core.io_mode |=> pins_reg.wp_io16 == !$past(core.port16)) // [RULE12]
    else $error("16-bit port pin wrong");
  AST_IOCS16: assert property (running && ide_reg |=> pins_reg.wp_io16 == !$past(core.word_xfer)) // [RULE13]
    else $error("Word transfer pin wrong");
  AST_RESET_QUIET: assert property (!running |=> !mem_we_reg && !cfg_we_reg && pins_reg.wp_io16) // [RULE15]
    else $error("Activity during reset");
endmodule

`default_nettype wire

// >>> bench/chpc_host.sv
// Purpose: Host adapter model that latches Ultra DMA read words
// Assumes: Behavioural; sees the card's strobe, data-enable and data pins only
// Notes: Gaps between strobe edges are simply waited out
`timescale 1ns/1ps
`default_nettype none
module chpc_host (
  input wire logic dstrobe,
  input wire logic data_oe,
  input wire logic [15:0] data
);
  logic [15:0] words[$];
  // ****************************************************************
  // Capture
  // ****************************************************************
  // One word on each strobe edge while data_oe is high, rising and falling alike
  // No edge means a pause, nothing to do
  always @(dstrobe) begin
    if (data_oe === 1'b1) begin
      words.push_back(data);
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_chpc_top.sv
// Purpose: Self-checking bench for the card host-pin control block
// Assumes: Init count shortened to 4 cycles
// Notes: Strobes are held for several cycles to clear the synchroniser
`timescale 1ns/1ps
`default_nettype none
module tb_chpc_top;
  import chpc_pkg::*;
  logic clk = 0;
  logic reset_n = 0;
  logic card_rst = 0;
  logic mode_n = 1;
  logic we_n = 1;
  chpc_core_t core = '0;
  logic [15:0] src_data = '0;
  logic src_valid = 0;
  logic src_ready, ide_mode, busy, mem_we, cfg_we;
  chpc_pins_t pins;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  logic m, c;

  always #12.5 clk = ~clk;
  chpc_top #(.INIT_CNT(4)) i_chpc_top (.clk(clk), .reset_n(reset_n), .pin_card_reset(card_rst),
    .pin_mode_sel_n(mode_n), .pin_we_n(we_n), .core(core), .src_data(src_data),
    .src_valid(src_valid), .src_ready(src_ready), .pins(pins), .ide_mode(ide_mode),
    .card_busy(busy), .mem_we_pulse(mem_we), .cfg_we_pulse(cfg_we));
  chpc_host i_chpc_host (.dstrobe(pins.dstrobe), .data_oe(pins.data_oe), .data(pins.data));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic complete_run();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  // Reset with a chosen mode strap, card reset pin left inactive
  task automatic rst(input logic md_n);
    @(posedge clk);
    reset_n <= 0;
    mode_n <= md_n;
    card_rst <= ~md_n;
    repeat (11) @(posedge clk);
    @(negedge clk);
    chk("busy_rst", 1, busy);
    chk("wp_rst", 1, pins.wp_io16);
    @(posedge clk);
    reset_n <= 1;
    repeat (200) begin
      @(negedge clk);
      if (busy === 1'b0) break;
    end
    chk("run", 0, busy);
  endtask

  // Hold card reset pin active and check the card stays parked
  task automatic card_reset_hold(input logic act);
    @(posedge clk);
    card_rst <= act;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("busy_pin", 1, busy);
    chk("wp_pin", 1, pins.wp_io16);
    // A host strobe while parked must be dropped
    we_strobe(m, c);
    chk("we_parked", 0, m | c);
    @(posedge clk);
    card_rst <= ~act;
    repeat (40) @(negedge clk);
    chk("run_pin", 0, busy);
  endtask

  // One write strobe; reports whether each pulse showed
  task automatic we_strobe(output logic mp, output logic cp);
    mp = 0;
    cp = 0;
    @(posedge clk);
    we_n <= 0;
    repeat (8) begin
      @(negedge clk);
      mp |= mem_we;
      cp |= cfg_we;
    end
    @(posedge clk);
    we_n <= 1;
    repeat (4) @(posedge clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_memory();
    rst(1);
    @(posedge clk);
    core.ready <= 0;
    repeat (3) @(negedge clk);
    chk("wp_mem", 0, pins.wp_io16);
    chk("wait_pc", 1, pins.wait_n);
    we_strobe(m, c);
    chk("mem_we", 1, m);
    chk("cfg_we_mem", 0, c);
    card_reset_hold(1);
  endtask

  task automatic t_io();
    @(posedge clk);
    core.io_mode <= 1;
    core.port16 <= 1;
    core.cfg_addr <= 0;
    repeat (3) @(negedge clk);
    chk("io16_on", 0, pins.wp_io16);
    @(posedge clk);
    core.port16 <= 0;
    repeat (3) @(negedge clk);
    chk("io16_off", 1, pins.wp_io16);
    we_strobe(m, c);
    chk("cfg_we_no", 0, c);
    chk("mem_we_io", 0, m);
    @(posedge clk);
    core.cfg_addr <= 1;
    we_strobe(m, c);
    chk("cfg_we", 1, c);
  endtask

  task automatic t_ide();
    core <= '0;
    rst(0);
    chk("ide", 1, ide_mode);
    @(posedge clk);
    core.word_xfer <= 1;
    core.ready <= 0;
    repeat (3) @(negedge clk);
    chk("cs16", 0, pins.wp_io16);
    chk("iordy0", 0, pins.wait_n);
    @(posedge clk);
    core.ready <= 1;
    core.udma_wr <= 1;
    core.wr_ready <= 0;
    repeat (3) @(negedge clk);
    chk("ddmardy", 0, pins.wait_n);
    @(posedge clk);
    core.wr_ready <= 1;
    repeat (3) @(negedge clk);
    chk("ddmardy1", 1, pins.wait_n);
    we_strobe(m, c);
    chk("we_ide", 0, m | c);
    @(posedge clk);
    core.udma_wr <= 0;
    card_reset_hold(0);
  endtask

  // Fill the FIFO until it refuses, then drain it to the host
  task automatic t_udma();
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      src_data <= 16'h5a00 + 16'(i);
      src_valid <= 1;
      @(negedge clk);
      chk("src_ready", (i < 8) ? 1 : 0, src_ready);
    end
    @(posedge clk);
    src_valid <= 0;
    core.udma_rd <= 1;
    repeat (40) @(negedge clk);
    chk("words", 8, 16'(i_chpc_host.words.size()));
    for (int i = 0; i < 8; i++) begin
      chk("word", 16'h5a00 + 16'(i), i_chpc_host.words[i]);
    end
    m = pins.dstrobe;
    repeat (10) @(negedge clk);
    chk("strobe_hold", m, pins.dstrobe);
    chk("oe", 1, pins.data_oe);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    t_memory();
    t_io();
    t_ide();
    t_udma();
    complete_run();
  end

  // Cuts a hang short well beyond the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
endmodule
`default_nettype wire
